// file: dv/pir_core_model.sv
// Processor core stand-in that acknowledges forwarded requests
`timescale 1ns/100ps
`default_nettype none
module pir_core_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Request in, delay choice, acknowledge out
   input  wire logic       irq_req,
   input  wire logic [1:0] dly,
   output logic            irq_ack
);
   logic [1:0] wait_ff;
   // Ack only while request is up, one cycle, so no stray ack is seen
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_ff <= 2'h0;
         irq_ack <= 1'b0;
      end else if (irq_ack || !irq_req) begin
         wait_ff <= 2'h0;
         irq_ack <= 1'b0;
      end else if (wait_ff == dly) begin
         irq_ack <= 1'b1;
      end else begin
         wait_ff <= wait_ff + 2'h1;
      end
   end
endmodule : pir_core_model
`default_nettype wire

// file: dv/pir_top_sva.sv
// Port checks of the interrupt request block
`timescale 1ns/100ps
`default_nettype none
module pir_top_sva (
   // Clock, reset, reads
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_rd_en,
   input wire logic [7:0]  reg_rdata,
   // Traps and global enable
   input wire logic        watchdog_req,
   input wire logic        watchdog_int_enable,
   input wire logic        gie_clear,
   input wire logic        global_interrupt_enable,
   // Core handshake
   input wire logic        irq_req,
   input wire logic [4:0]  irq_src,
   input wire logic        irq_ack,
   input wire logic [3:0]  port_c_ack_clear
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   property p_rst; $rose(rst_b) |-> !irq_req && !global_interrupt_enable && reg_rdata == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values");
   property p_ack; irq_req && irq_ack |=> !irq_req && !global_interrupt_enable; endproperty
   a_ack: assert property (p_ack) else $error("ack");
   property p_off; !global_interrupt_enable |=> !irq_req; endproperty
   a_off: assert property (p_off) else $error("request while disabled");
   property p_clr; gie_clear |=> !global_interrupt_enable; endproperty
   a_clr: assert property (p_clr) else $error("enable clear");
   property p_trap; watchdog_req && watchdog_int_enable && global_interrupt_enable && !irq_ack
      && !gie_clear |=> irq_req && irq_src == 5'h00; endproperty
   a_trap: assert property (p_trap) else $error("watchdog");
   property p_unmap; reg_rd_en && reg_addr != 12'hFC0 && reg_addr != 12'hFC3 |=> reg_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_pcack; irq_req && irq_ack && irq_src >= 5'h10 |->
      port_c_ack_clear == (4'h8 >> (irq_src - 5'h10)); endproperty
   a_pcack: assert property (p_pcack) else $error("port c clear");
   property p_pcidle; !(irq_req && irq_ack && irq_src >= 5'h10) |-> port_c_ack_clear == 4'h0;
   endproperty
   a_pcidle: assert property (p_pcidle) else $error("stray port c clear");
endmodule : pir_top_sva
bind pir_top pir_top_sva i_sva (.*);
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the interrupt request block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk, rst_b, reg_wr_en, reg_rd_en, gie_set, gie_clear, irq_ack, irq_req;
   logic timer_one_req, timer_zero_req, serial_receive_req, serial_transmit_req, converter_req;
   logic watchdog_req, watchdog_int_enable, primary_osc_fail, watchdog_osc_fail;
   logic global_interrupt_enable;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, port_a_req, ma, mb;
   logic [7:0]  bank_a_priority_high_bits, bank_a_priority_low_bits;
   logic [7:0]  bank_b_priority_high_bits, bank_b_priority_low_bits;
   logic [3:0]  port_c_pending, port_c_priority_high_bits, port_c_priority_low_bits;
   logic [3:0]  port_c_ack_clear;
   logic [4:0]  irq_src;
   logic [1:0]  dly;
   int          errors, samples_checked, cyc, seed, it;
   pir_top i_dut (.*);
   pir_core_model i_core (.clk(clk), .rst_b(rst_b), .irq_req(irq_req), .dly(dly), .irq_ack(irq_ack));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stp();
      @(posedge clk) #1;
   endtask : stp
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Single access per write, never read-modify-write, so no pulse is lost
   task automatic acc(logic w, logic [11:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      {reg_wr_en, reg_rd_en} = {w, !w};
      stp();
      {reg_wr_en, reg_rd_en} = 2'h0;
      if (!w) chk("reg_rdata", d, reg_rdata);
      stp();
   endtask : acc
   function automatic int exp_win();
      logic [0:19] r, h, l;
      r = {watchdog_req & watchdog_int_enable, primary_osc_fail, watchdog_osc_fail, ma[6:3], ma[0],
         mb, port_c_pending};
      h = {3'h7, bank_a_priority_high_bits[6:3], bank_a_priority_high_bits[0],
         bank_b_priority_high_bits, port_c_priority_high_bits};
      l = {3'h7, bank_a_priority_low_bits[6:3], bank_a_priority_low_bits[0],
         bank_b_priority_low_bits, port_c_priority_low_bits};
      for (int v = 3; v > 0; v--)
         for (int i = 0; i < 20; i++)
            if (r[i] && {h[i], l[i]} == 2'(v)) return i;
      return -1;
   endfunction : exp_win
   task automatic serve();
      int e;
      e = exp_win();
      gie_set = 1'b1;
      stp();
      gie_set = 1'b0;
      for (int k = 0; k < 12 && irq_ack !== 1'b1; k++) stp();
      if (e < 0) begin
         chk("irq_req", 8'h0, {7'h0, irq_req});
         gie_clear = 1'b1;
         stp();
         gie_clear = 1'b0;
      end else begin
         chk("irq_req", 8'h1, {7'h0, irq_req});
         chk("irq_src", 8'(e), {3'h0, irq_src});
         chk("ack_clear", (e > 15) ? 8'(1 << (19 - e)) : 8'h0, {4'h0, port_c_ack_clear});
         stp();
         if (e > 15) port_c_pending[19-e] = 1'b0;
         else if (e > 7) mb[15-e] = 1'b0;
         else if (e > 2) ma[(e == 7) ? 0 : 9 - e] = 1'b0;
         chk("gie", 8'h0, {7'h0, global_interrupt_enable});
      end
   endtask : serve
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      seed = 32'h267D735A;
      {rst_b, reg_wr_en, reg_rd_en, gie_set, gie_clear, reg_addr, reg_wdata, dly, ma} = '0;
      {timer_one_req, timer_zero_req, serial_receive_req, serial_transmit_req, converter_req} = '0;
      {watchdog_req, watchdog_int_enable, primary_osc_fail, watchdog_osc_fail, port_a_req} = '0;
      {bank_a_priority_high_bits, bank_a_priority_low_bits, port_c_pending} = '0;
      {bank_b_priority_high_bits, bank_b_priority_low_bits, port_c_priority_high_bits} = '0;
      port_c_priority_low_bits = 4'h0;
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      acc(1'b0, 12'hFC0, 8'h00);
      acc(1'b0, 12'hFC3, 8'h00);
      acc(1'b0, 12'hFE0, 8'h00);
      $display("test reset done");
      port_a_req = 8'($random(seed));
      {timer_one_req, timer_zero_req, serial_receive_req, serial_transmit_req, converter_req} = 5'h1F;
      stp();
      {timer_one_req, timer_zero_req, serial_receive_req, serial_transmit_req, converter_req} = 5'h0;
      {ma, mb, port_a_req} = {8'h79, port_a_req, 8'h00};
      acc(1'b0, 12'hFC0, ma);
      acc(1'b0, 12'hFC3, mb);
      for (it = 0; it < 16; it++) begin
         {bank_a_priority_high_bits, bank_a_priority_low_bits} = 16'($random(seed));
         {bank_b_priority_high_bits, bank_b_priority_low_bits} = 16'($random(seed));
         {port_c_priority_high_bits, port_c_priority_low_bits, port_c_pending, dly} = 14'($random(seed));
         if (it > 0) begin
            ma = 8'($random(seed)) & 8'h79;
            mb = 8'($random(seed));
            acc(1'b1, 12'hFC0, ma);
            acc(1'b1, 12'hFC3, mb);
         end
         chk("irq_req", 8'h0, {7'h0, irq_req});
         repeat (21) serve();
         acc(1'b0, 12'hFC0, ma);
         acc(1'b0, 12'hFC3, mb);
      end
      $display("test arbitration done");
      for (it = 0; it < 3; it++) begin
         {watchdog_osc_fail, primary_osc_fail, watchdog_req, watchdog_int_enable} = 4'(2 * (1 << it) + 1);
         serve();
         // Handler has polled the status flag clear, so the level drops
         {watchdog_osc_fail, primary_osc_fail, watchdog_req} = 3'h0;
      end
      $display("test traps done");
      // Clear of the whole bank in the cycle of a pulse: pulse must survive
      reg_addr  = 12'hFC0;
      reg_wdata = 8'h00;
      reg_wr_en = 1'b1;
      timer_one_req = 1'b1;
      stp();
      {reg_wr_en, timer_one_req} = 2'h0;
      ma = 8'h40;
      acc(1'b0, 12'hFC0, ma);
      // Reset in mid-run empties both banks and the read register
      rst_b = 1'b0;
      stp();
      rst_b = 1'b1;
      acc(1'b0, 12'hFC0, 8'h00);
      acc(1'b0, 12'hFC3, 8'h00);
      chk("gie", 8'h0, {7'h0, global_interrupt_enable});
      $display("test pulse and reset done");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire

// file: verilog/pir_arbiter.sv
// Fixed-order three-level priority picker
`timescale 1ns/100ps
`default_nettype none

module pir_arbiter #(
   parameter int NUM_SRC = 20,
   parameter int ID_W    = 5
) (
   // Requests and enable pairs, index 0 first in order
   input  wire logic [NUM_SRC-1:0] req,
   input  wire logic [NUM_SRC-1:0] lvl_hi,
   input  wire logic [NUM_SRC-1:0] lvl_lo,
   // Winner
   output logic                    win_valid,
   output logic [ID_W-1:0]         win_id
);

   function automatic pir_pkg::pir_level_t level_of(input logic hi, input logic lo);
      level_of = pir_pkg::pir_level_t'({hi, lo});
   endfunction : level_of

   pir_pkg::pir_level_t best;

   // Strict compare keeps the earliest source on a tie
   always_comb begin
      win_valid = 1'b0;
      win_id    = '0;
      best      = pir_pkg::PIR_LVL_OFF;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (req[i] && (level_of(lvl_hi[i], lvl_lo[i]) > best)) begin
            best      = level_of(lvl_hi[i], lvl_lo[i]);
            win_id    = ID_W'(i);
            win_valid = 1'b1;
         end
      end
   end

endmodule : pir_arbiter

`default_nettype wire

// file: verilog/pir_map.svh
// Register offsets, bit positions and reset values of the interrupt request block
// Summary of operation
// - Level 3 beats 2, 2 beats 1
// - Same level: earlier-listed source wins
// - Watchdog, primary and watchdog oscillator traps: level 3
// - One-cycle source pulse caught in sticky bit
// - Request sets matching pending bit to 1
// - Acknowledge clears pending bit until next pulse
// - Software write of 0 clears request
// - Software write of 1 raises request
// - Watchdog request held while time-out persists
// - Watchdog and oscillator traps bypass registers
// - Forward winner if enabled, else polling only
// - Bank A bits: 6,5,4,3,0; reset zero
// - Bank B: port A pins; reset zero
// - Enable pair: 00 off, 01..11 levels
// - Acknowledge clears global interrupt enable
// - Order: watchdog and oscillator traps, timers, serial, converter, port A, port C
`ifndef PIR_MAP_SVH
`define PIR_MAP_SVH

`define PIR_BANK_A_ADDR   12'hFC0
`define PIR_BANK_B_ADDR   12'hFC3
`define PIR_BANK_RESET    8'h00
`define PIR_UNMAPPED_READ 8'h00

`define PIR_A_TIMER1_BIT  6
`define PIR_A_TIMER0_BIT  5
`define PIR_A_SER_RX_BIT  4
`define PIR_A_SER_TX_BIT  3
`define PIR_A_CONV_BIT    0

`define PIR_NUM_SRC       20

`endif

// file: verilog/pir_pkg.sv
// Types shared by the interrupt request block
package pir_pkg;

   typedef enum logic [1:0] {
      PIR_LVL_OFF = 2'h0,
      PIR_LVL_ONE = 2'h1,
      PIR_LVL_TWO = 2'h2,
      PIR_LVL_TOP = 2'h3
   } pir_level_t;

   // Source index in fixed service order, lowest index first
   typedef enum logic [4:0] {
      PIR_SRC_WDOG     = 5'h00,
      PIR_SRC_PRI_OSC  = 5'h01,
      PIR_SRC_WDOG_OSC = 5'h02,
      PIR_SRC_TIMER1   = 5'h03,
      PIR_SRC_TIMER0   = 5'h04,
      PIR_SRC_SER_RX   = 5'h05,
      PIR_SRC_SER_TX   = 5'h06,
      PIR_SRC_CONV     = 5'h07,
      PIR_SRC_PA_BASE  = 5'h08,
      PIR_SRC_PC_BASE  = 5'h10
   } pir_src_t;

endpackage : pir_pkg

// file: verilog/pir_top.sv
// Interrupt request capture, priority and forwarding to the core
`timescale 1ns/100ps
`default_nettype none
`include "pir_map.svh"

module pir_top (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [11:0] reg_addr,
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Ordinary source pulses
   input  wire logic       timer_one_req,
   input  wire logic       timer_zero_req,
   input  wire logic       serial_receive_req,
   input  wire logic       serial_transmit_req,
   input  wire logic       converter_req,
   input  wire logic [7:0] port_a_req,
   // Sources that bypass the registers
   input  wire logic       watchdog_req,
   input  wire logic       watchdog_int_enable,
   input  wire logic       primary_osc_fail,
   input  wire logic       watchdog_osc_fail,
   // Enable and priority pairs
   input  wire logic [7:0] bank_a_priority_high_bits,
   input  wire logic [7:0] bank_a_priority_low_bits,
   input  wire logic [7:0] bank_b_priority_high_bits,
   input  wire logic [7:0] bank_b_priority_low_bits,
   // Port C requests held elsewhere
   input  wire logic [3:0] port_c_pending,
   input  wire logic [3:0] port_c_priority_high_bits,
   input  wire logic [3:0] port_c_priority_low_bits,
   output logic      [3:0] port_c_ack_clear,
   // Global enable
   input  wire logic       gie_set,
   input  wire logic       gie_clear,
   output logic            global_interrupt_enable,
   // Core handshake
   output logic            irq_req,
   output logic      [4:0] irq_src,
   input  wire logic       irq_ack
);

   localparam int NUM_SRC = `PIR_NUM_SRC;
   localparam int PA_BASE = int'(pir_pkg::PIR_SRC_PA_BASE);
   localparam int PC_BASE = int'(pir_pkg::PIR_SRC_PC_BASE);

   logic [7:0]         bank_a_ff, nxt_bank_a;
   logic [7:0]         bank_b_ff, nxt_bank_b;
   logic [7:0]         rdata_ff, nxt_rdata;
   logic               gie_ff, nxt_gie;
   logic               req_ff, nxt_req;
   logic [4:0]         src_ff, nxt_src;
   logic [7:0]         pulse_a, clr_a, clr_b;
   logic [3:0]         clr_c;
   logic [NUM_SRC-1:0] src_req, src_hi, src_lo;
   logic               win_valid;
   logic [4:0]         win_id;
   logic               ack_take;

   ////////////////////////////////////////////////////////////////////////////////
   // Source vector in service order

   always_comb begin
      src_req = '0;
      src_hi  = '0;
      src_lo  = '0;
      // Watchdog is a level, not latched: it is held by its source
      src_req[pir_pkg::PIR_SRC_WDOG]     = watchdog_req & watchdog_int_enable;
      src_req[pir_pkg::PIR_SRC_PRI_OSC]  = primary_osc_fail;
      src_req[pir_pkg::PIR_SRC_WDOG_OSC] = watchdog_osc_fail;
      for (int i = 0; i < 3; i++) begin
         src_hi[i] = 1'b1;
         src_lo[i] = 1'b1;
      end
      src_req[pir_pkg::PIR_SRC_TIMER1] = bank_a_ff[`PIR_A_TIMER1_BIT];
      src_req[pir_pkg::PIR_SRC_TIMER0] = bank_a_ff[`PIR_A_TIMER0_BIT];
      src_req[pir_pkg::PIR_SRC_SER_RX] = bank_a_ff[`PIR_A_SER_RX_BIT];
      src_req[pir_pkg::PIR_SRC_SER_TX] = bank_a_ff[`PIR_A_SER_TX_BIT];
      src_req[pir_pkg::PIR_SRC_CONV]   = bank_a_ff[`PIR_A_CONV_BIT];
      src_hi[pir_pkg::PIR_SRC_TIMER1]  = bank_a_priority_high_bits[`PIR_A_TIMER1_BIT];
      src_hi[pir_pkg::PIR_SRC_TIMER0]  = bank_a_priority_high_bits[`PIR_A_TIMER0_BIT];
      src_hi[pir_pkg::PIR_SRC_SER_RX]  = bank_a_priority_high_bits[`PIR_A_SER_RX_BIT];
      src_hi[pir_pkg::PIR_SRC_SER_TX]  = bank_a_priority_high_bits[`PIR_A_SER_TX_BIT];
      src_hi[pir_pkg::PIR_SRC_CONV]    = bank_a_priority_high_bits[`PIR_A_CONV_BIT];
      src_lo[pir_pkg::PIR_SRC_TIMER1]  = bank_a_priority_low_bits[`PIR_A_TIMER1_BIT];
      src_lo[pir_pkg::PIR_SRC_TIMER0]  = bank_a_priority_low_bits[`PIR_A_TIMER0_BIT];
      src_lo[pir_pkg::PIR_SRC_SER_RX]  = bank_a_priority_low_bits[`PIR_A_SER_RX_BIT];
      src_lo[pir_pkg::PIR_SRC_SER_TX]  = bank_a_priority_low_bits[`PIR_A_SER_TX_BIT];
      src_lo[pir_pkg::PIR_SRC_CONV]    = bank_a_priority_low_bits[`PIR_A_CONV_BIT];
      // Port A pin 7 first, down to pin 0, then port C pin 3 down to 0
      for (int k = 0; k < 8; k++) begin
         src_req[PA_BASE+k] = bank_b_ff[7-k];
         src_hi[PA_BASE+k]  = bank_b_priority_high_bits[7-k];
         src_lo[PA_BASE+k]  = bank_b_priority_low_bits[7-k];
      end
      for (int k = 0; k < 4; k++) begin
         src_req[PC_BASE+k] = port_c_pending[3-k];
         src_hi[PC_BASE+k]  = port_c_priority_high_bits[3-k];
         src_lo[PC_BASE+k]  = port_c_priority_low_bits[3-k];
      end
   end

   pir_arbiter #(
      .NUM_SRC (NUM_SRC),
      .ID_W    (5)
   ) u_arbiter (
      .req       (src_req),
      .lvl_hi    (src_hi),
      .lvl_lo    (src_lo),
      .win_valid (win_valid),
      .win_id    (win_id)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Acknowledge decode

   assign ack_take = irq_ack & req_ff;

   always_comb begin
      clr_a = 8'h00;
      clr_b = 8'h00;
      clr_c = 4'h0;
      if (ack_take) begin
         if (src_ff == pir_pkg::PIR_SRC_TIMER1) begin
            clr_a[`PIR_A_TIMER1_BIT] = 1'b1;
         end else if (src_ff == pir_pkg::PIR_SRC_TIMER0) begin
            clr_a[`PIR_A_TIMER0_BIT] = 1'b1;
         end else if (src_ff == pir_pkg::PIR_SRC_SER_RX) begin
            clr_a[`PIR_A_SER_RX_BIT] = 1'b1;
         end else if (src_ff == pir_pkg::PIR_SRC_SER_TX) begin
            clr_a[`PIR_A_SER_TX_BIT] = 1'b1;
         end else if (src_ff == pir_pkg::PIR_SRC_CONV) begin
            clr_a[`PIR_A_CONV_BIT] = 1'b1;
         end
         for (int k = 0; k < 8; k++) begin
            if (src_ff == 5'(PA_BASE + k)) begin
               clr_b[7-k] = 1'b1;
            end
         end
         for (int k = 0; k < 4; k++) begin
            if (src_ff == 5'(PC_BASE + k)) begin
               clr_c[3-k] = 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pending registers

   always_comb begin
      pulse_a = 8'h00;
      pulse_a[`PIR_A_TIMER1_BIT] = timer_one_req;
      pulse_a[`PIR_A_TIMER0_BIT] = timer_zero_req;
      pulse_a[`PIR_A_SER_RX_BIT] = serial_receive_req;
      pulse_a[`PIR_A_SER_TX_BIT] = serial_transmit_req;
      pulse_a[`PIR_A_CONV_BIT]   = converter_req;
      nxt_bank_a = bank_a_ff;
      nxt_bank_b = bank_b_ff;
      // Written value sets or clears bits; reserved bits simply store
      if (reg_wr_en && (reg_addr == `PIR_BANK_A_ADDR)) begin
         nxt_bank_a = reg_wdata;
      end else if (reg_wr_en && (reg_addr == `PIR_BANK_B_ADDR)) begin
         nxt_bank_b = reg_wdata;
      end
      nxt_bank_a = (nxt_bank_a & ~clr_a) | pulse_a;
      nxt_bank_b = (nxt_bank_b & ~clr_b) | port_a_req;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, global enable, core request

   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd_en) begin
         if (reg_addr == `PIR_BANK_A_ADDR) begin
            nxt_rdata = bank_a_ff;
         end else if (reg_addr == `PIR_BANK_B_ADDR) begin
            nxt_rdata = bank_b_ff;
         end else begin
            nxt_rdata = `PIR_UNMAPPED_READ;
         end
      end
      nxt_gie = gie_ff;
      if (gie_set) begin
         nxt_gie = 1'b1;
      end
      if (gie_clear || ack_take) begin
         nxt_gie = 1'b0;
      end
      // Dropped on ack so the stale winner is never offered twice
      nxt_req = gie_ff & win_valid & ~ack_take;
      nxt_src = win_id;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bank_a_ff <= `PIR_BANK_RESET;
         bank_b_ff <= `PIR_BANK_RESET;
         rdata_ff  <= `PIR_BANK_RESET;
         gie_ff    <= 1'b0;
         req_ff    <= 1'b0;
         src_ff    <= 5'h00;
      end else begin
         bank_a_ff <= nxt_bank_a;
         bank_b_ff <= nxt_bank_b;
         rdata_ff  <= nxt_rdata;
         gie_ff    <= nxt_gie;
         req_ff    <= nxt_req;
         src_ff    <= nxt_src;
      end
   end

   assign reg_rdata               = rdata_ff;
   assign global_interrupt_enable = gie_ff;
   assign irq_req                 = req_ff;
   assign irq_src                 = src_ff;
   assign port_c_ack_clear        = clr_c;

endmodule : pir_top

`default_nettype wire
